// *** faec_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Array read data is 0 for erased bits and 1 for programmed bits.
// [R2] Rows hold 8 pages of 8 bytes; erase by 64-byte row, program by page.
// [R3] Storage windows 0450-04FF, 0580-05FF, 0E00-7FFF; control register at FE11.
// [R4] Software programs each page once per row between erases.
// [R5] Software uses minimal program time with program and margin read loops.
// [R6] Pump clock is bus clock divided by 1, 2, 2 or 4 per divider field.
// [R7] Software avoids high-voltage work below 2 MHz bus clock.
// [R8] Software writes equal divider values in both arrays.
// [R9] High voltage only with program or erase selected and sequence followed.
// [R10] Margin select refused while high voltage is enabled.
// [R11] Erase and program selects never both set.
// [R12] Software first selects erase with block size and divider.
// [R13] Software reads protect byte at FF81 before enabling high voltage.
// [R14] Software then writes any data inside the block to erase.
// [R15] Setup write latches cared address bits choosing the block.
// [R16] Block size: full array, half by A14, 512 bytes A14-A9, row A14-A6.
// [R17] Full-array erase arms on a setup write to any storage window.
// [R18] Software sets, holds, clears high voltage then clears erase and waits.
// [R19] Steps stay ordered; unrelated bus activity between steps is tolerated.
// [R20] Protect byte latched on read; overlapping operation clears its mode bit.
// [R21] Margin read stretches each array read by eight extra bus cycles.
// [R22] Wait or stop mode turns the pump off while mode bits persist.
// [R23] Reset clears all control fields: normal read, high voltage off.
module faec_top
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  array_sense_i,
  input  wire logic        protect_bypass_i,
  input  wire logic        low_power_i,
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             busy_o,
  output logic      [7:0]  ctrl_o,
  output logic             pump_clk_en_o,
  output logic             pump_on_o,
  output logic             hv_array_o,
  output logic      [8:0]  erase_block_o,
  output logic      [8:0]  erase_mask_o,
  output logic      [11:0] program_page_o,
  output logic             prog_latch_o
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= faec_pkg::WIN0_LO && a <= faec_pkg::WIN0_HI) ||
               (a >= faec_pkg::WIN1_LO && a <= faec_pkg::WIN1_HI) ||
               (a >= faec_pkg::WIN2_LO && a <= faec_pkg::WIN2_HI); // [R3]
  endfunction

  // Cared bits A14..A6 for each block size
  function automatic logic [8:0] blk_mask(input logic [1:0] blk);
    case (blk)
      2'b00:   blk_mask = 9'h000;
      2'b01:   blk_mask = 9'h100;
      2'b10:   blk_mask = 9'h1f8;
      2'b11:   blk_mask = 9'h1ff;
      default: blk_mask = 9'h000;
    endcase // [R16]
  endfunction

  // Lowest protected address from the latched protect byte
  function automatic logic [15:0] prot_floor(input logic [3:0] p);
    if (p[0])
      prot_floor = faec_pkg::PROT_THR0;
    else if (p[1])
      prot_floor = faec_pkg::PROT_THR1;
    else if (p[2])
      prot_floor = faec_pkg::PROT_THR2;
    else if (p[3])
      prot_floor = faec_pkg::PROT_THR3;
    else
      prot_floor = 16'hffff;
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0]          ctrl_q;
  logic [3:0]          protect_q;
  faec_pkg::faec_seq_t seq_q;
  logic [3:0]          stretch_q;
  logic                pend_q;
  logic [8:0]          cur_mask;
  logic [8:0]          ers_blk;
  logic [15:0]         top_addr;
  logic                hits_prot;
  logic                ctrl_wr;
  logic                arr_wr;
  logic                mode_on;
  faec_pump_if         pump ();

  assign mode_on  = ctrl_q[faec_pkg::PGM_BIT] | ctrl_q[faec_pkg::ERASE_BIT];
  assign ctrl_wr  = wr_i && addr_i == faec_pkg::CTRL_ADDR;
  assign arr_wr   = wr_i && in_array(addr_i);
  assign cur_mask = blk_mask(ctrl_q[faec_pkg::BLK_LSB +: 2]);
  assign ers_blk  = addr_i[14:6] & cur_mask; // [R15]

  // Highest address touched by the operation this write arms
  always_comb
  begin
    if (ctrl_q[faec_pkg::ERASE_BIT])
      top_addr = {1'b0, ers_blk | ~cur_mask, 6'h3f};
    else
      top_addr = {1'b0, addr_i[14:3], 3'h7}; // [R2]
    hits_prot = !protect_bypass_i && top_addr >= prot_floor(protect_q); // [R20]
  end

  // ****************************************************
  // Control register
  // ****************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_q <= faec_pkg::CTRL_RESET; // [R23]
    else if (ctrl_wr)
    begin
      ctrl_q[7:4] <= wdata_i[7:4];
      // Conflicting selects keep the previous mode rather than guess
      if (!(wdata_i[faec_pkg::PGM_BIT] && wdata_i[faec_pkg::ERASE_BIT]))
      begin
        ctrl_q[faec_pkg::PGM_BIT]   <= wdata_i[faec_pkg::PGM_BIT]; // [R11]
        ctrl_q[faec_pkg::ERASE_BIT] <= wdata_i[faec_pkg::ERASE_BIT]; // [R11]
      end
      ctrl_q[faec_pkg::MARGIN_BIT] <= wdata_i[faec_pkg::MARGIN_BIT] &&
                                      !ctrl_q[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT] &&
                                      !wdata_i[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT]; // [R10]
      ctrl_q[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT]   <= wdata_i[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT] && mode_on &&
                                      wdata_i[faec_pkg::PGM_BIT +: 2] ==
                                      ctrl_q[faec_pkg::PGM_BIT +: 2] &&
                                      seq_q == faec_pkg::SEQ_ARMED; // [R9]
    end
    else if (arr_wr && mode_on && seq_q != faec_pkg::SEQ_IDLE && hits_prot)
    begin
      ctrl_q[faec_pkg::PGM_BIT]   <= 1'b0; // [R20]
      ctrl_q[faec_pkg::ERASE_BIT] <= 1'b0; // [R20]
      ctrl_q[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT]  <= 1'b0; // [R20]
    end
  end

  // ****************************************************
  // Sequence tracking
  // ****************************************************
  // Only matching accesses advance; other bus traffic leaves the state alone
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      seq_q <= faec_pkg::SEQ_IDLE;
    else
    begin
      case (seq_q)
        faec_pkg::SEQ_IDLE:
          if (ctrl_wr && (wdata_i[faec_pkg::PGM_BIT] ^ wdata_i[faec_pkg::ERASE_BIT]))
            seq_q <= faec_pkg::SEQ_MODE; // [R19]
        faec_pkg::SEQ_MODE:
          if (ctrl_wr && !(wdata_i[faec_pkg::PGM_BIT] | wdata_i[faec_pkg::ERASE_BIT]))
            seq_q <= faec_pkg::SEQ_IDLE;
          else if (rd_i && addr_i == faec_pkg::PROTECT_ADDR)
            seq_q <= faec_pkg::SEQ_PROT; // [R19]
        faec_pkg::SEQ_PROT:
          if (!mode_on || (ctrl_wr && !(wdata_i[faec_pkg::PGM_BIT] |
                                       wdata_i[faec_pkg::ERASE_BIT])))
            seq_q <= faec_pkg::SEQ_IDLE;
          else if (arr_wr)
            seq_q <= hits_prot ? faec_pkg::SEQ_IDLE : faec_pkg::SEQ_ARMED; // [R17]
        faec_pkg::SEQ_ARMED:
          if (!mode_on || (ctrl_wr && !(wdata_i[faec_pkg::PGM_BIT] |
                                       wdata_i[faec_pkg::ERASE_BIT])))
            seq_q <= faec_pkg::SEQ_IDLE;
        default:
          seq_q <= faec_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Protect latch and block/page address latch
  // ****************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      protect_q <= 4'h0;
    else if (rd_i && addr_i == faec_pkg::PROTECT_ADDR)
      protect_q <= ~array_sense_i[3:0]; // [R20]
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      erase_block_o  <= 9'h000;
      erase_mask_o   <= 9'h000;
      program_page_o <= 12'h000;
      prog_latch_o   <= 1'b0;
    end
    else
    begin
      prog_latch_o <= 1'b0;
      if (arr_wr && ctrl_q[faec_pkg::ERASE_BIT] && seq_q == faec_pkg::SEQ_PROT)
      begin
        erase_block_o <= ers_blk; // [R15]
        erase_mask_o  <= cur_mask; // [R16]
      end
      if (arr_wr && ctrl_q[faec_pkg::PGM_BIT] && seq_q != faec_pkg::SEQ_IDLE && !hits_prot)
      begin
        program_page_o <= addr_i[14:3]; // [R2]
        prog_latch_o   <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Read path with margin stretch
  // ****************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o   <= 8'h00;
      rvalid_o  <= 1'b0;
      busy_o    <= 1'b0;
      stretch_q <= 4'h0;
      pend_q    <= 1'b0;
    end
    else
    begin
      rvalid_o <= 1'b0;
      if (pend_q)
      begin
        if (stretch_q == 4'h1)
        begin
          pend_q   <= 1'b0;
          busy_o   <= 1'b0;
          rvalid_o <= 1'b1;
          rdata_o  <= ~array_sense_i; // [R1]
        end
        stretch_q <= stretch_q - 4'h1; // [R21]
      end
      else if (rd_i)
      begin
        if (in_array(addr_i) && ctrl_q[faec_pkg::MARGIN_BIT])
        begin
          pend_q    <= 1'b1;
          busy_o    <= 1'b1;
          stretch_q <= faec_pkg::MARGIN_STRETCH; // [R21]
        end
        else
        begin
          rvalid_o <= 1'b1;
          if (addr_i == faec_pkg::CTRL_ADDR)
            rdata_o <= ctrl_q;
          else if (in_array(addr_i) || addr_i == faec_pkg::PROTECT_ADDR)
            rdata_o <= ~array_sense_i; // [R1]
          else
            rdata_o <= 8'h00;
        end
      end
    end
  end

  // ****************************************************
  // Pump and high voltage
  // ****************************************************
  assign pump.div_sel = ctrl_q[faec_pkg::FDIV_LSB +: 2];
  assign pump.run     = ctrl_q[faec_pkg::HIGH_VOLTAGE_ENABLE_BIT] && !low_power_i; // [R22]

  faec_pump_div faec_pump_div_i
  (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .pump   (pump.div)
  );

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pump_on_o     <= 1'b0;
      hv_array_o    <= 1'b0;
      pump_clk_en_o <= 1'b0;
      ctrl_o        <= faec_pkg::CTRL_RESET;
    end
    else
    begin
      pump_on_o     <= pump.run; // [R9]
      hv_array_o    <= pump.run; // [R22]
      pump_clk_en_o <= pump.tick; // [R6]
      ctrl_o        <= ctrl_q;
    end
  end

endmodule

// *** faec_pkg.sv ***
package faec_pkg;

  // ****************************************************
  // Address map
  // ****************************************************
  localparam logic [15:0] CTRL_ADDR    = 16'hfe11;
  localparam logic [15:0] PROTECT_ADDR = 16'hff81;
  localparam logic [15:0] WIN0_LO      = 16'h0450;
  localparam logic [15:0] WIN0_HI      = 16'h04ff;
  localparam logic [15:0] WIN1_LO      = 16'h0580;
  localparam logic [15:0] WIN1_HI      = 16'h05ff;
  localparam logic [15:0] WIN2_LO      = 16'h0e00;
  localparam logic [15:0] WIN2_HI      = 16'h7fff;

  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int          PGM_BIT    = 0;
  localparam int          ERASE_BIT  = 1;
  localparam int          MARGIN_BIT = 2;
  localparam int          HIGH_VOLTAGE_ENABLE_BIT   = 3;
  localparam int          BLK_LSB    = 4;
  localparam int          FDIV_LSB   = 6;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // ****************************************************
  // Protection thresholds, one per protect bit
  // ****************************************************
  localparam logic [15:0] PROT_THR0 = 16'h0450;
  localparam logic [15:0] PROT_THR1 = 16'h1000;
  localparam logic [15:0] PROT_THR2 = 16'h2000;
  localparam logic [15:0] PROT_THR3 = 16'h4000;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam logic [3:0]  MARGIN_STRETCH = 4'h8;

  typedef enum logic [1:0] {
    DIV_BY1  = 2'b00,
    DIV_BY2A = 2'b01,
    DIV_BY2B = 2'b10,
    DIV_BY4  = 2'b11
  } faec_div_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_MODE  = 2'b01,
    SEQ_PROT  = 2'b10,
    SEQ_ARMED = 2'b11
  } faec_seq_t;

endpackage

// *** faec_pump_if.sv ***
`timescale 1ns/1ps
interface faec_pump_if;
  logic [1:0] div_sel;
  logic       run;
  logic       tick;
  modport ctrl (output div_sel, output run, input tick);
  modport div  (input div_sel, input run, output tick);
endinterface

// *** faec_pump_div.sv ***
`timescale 1ns/1ps
module faec_pump_div
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  faec_pump_if.div  pump
);

  logic [1:0] cnt_q;
  logic [1:0] last_q;

  always_comb
  begin
    case (faec_pkg::faec_div_t'(pump.div_sel))
      faec_pkg::DIV_BY1:  last_q = 2'h0;
      faec_pkg::DIV_BY2A: last_q = 2'h1;
      faec_pkg::DIV_BY2B: last_q = 2'h1;
      faec_pkg::DIV_BY4:  last_q = 2'h3;
      default:            last_q = 2'h0;
    endcase
  end

  // Pump clock is a one-cycle enable at bus rate / N, so divide-by-1 needs no gated clock
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q     <= 2'h0;
      pump.tick <= 1'b0;
    end
    else if (!pump.run)
    begin
      cnt_q     <= 2'h0;
      pump.tick <= 1'b0;
    end
    else
    begin
      pump.tick <= (cnt_q >= last_q); // [R6]
      cnt_q     <= (cnt_q >= last_q) ? 2'h0 : cnt_q + 2'h1; // [R6]
    end
  end

endmodule

// *** faec_top_properties.sv ***
`timescale 1ns/1ps
module faec_top_chk
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [15:0] addr_i,
  input wire logic        rd_i,
  input wire logic        low_power_i,
  input wire logic        rvalid_o,
  input wire logic        busy_o,
  input wire logic [7:0]  ctrl_o,
  input wire logic        pump_clk_en_o,
  input wire logic        pump_on_o,
  input wire logic        hv_array_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence stretch_s;
    busy_o [*8] ##1 rvalid_o;
  endsequence

  a_mode_bits_excl: assert property (!(ctrl_o[0] && ctrl_o[1]))
    else $error("program and erase both selected");
  a_hv_needs_mode: assert property (hv_array_o |-> ctrl_o[0] || ctrl_o[1])
    else $error("high voltage without a mode bit");
  a_hv_pump_pair: assert property ((hv_array_o == pump_on_o) &&
    (pump_on_o == (ctrl_o[3] && !$past(low_power_i))))
    else $error("pump or array voltage disagrees with enable");
  a_margin_no_hv: assert property (!(ctrl_o[2] && ctrl_o[3]))
    else $error("margin set with high voltage");
  a_low_power_off: assert property (low_power_i |=> !pump_on_o && !hv_array_o)
    else $error("pump still on in low power");
  a_pump_tick_on: assert property (pump_clk_en_o |-> pump_on_o || $past(pump_on_o))
    else $error("pump tick while pump off");
  a_read_answer: assert property (rd_i && !busy_o && !ctrl_o[2] |=> rvalid_o)
    else $error("read not answered next cycle");
  a_margin_stretch: assert property (rd_i && !busy_o && ctrl_o[2] &&
    addr_i inside {[16'h0e00:16'h7fff]} |=> stretch_s)
    else $error("margin read not stretched by eight");
  a_reset_clear: assert property ($rose(rstn_i) |-> ctrl_o == 8'h00)
    else $error("control not clear after reset");
endmodule

bind faec_top faec_top_chk faec_top_chk_i
(
  .clk_i         (clk_i),
  .rstn_i        (rstn_i),
  .addr_i        (addr_i),
  .rd_i          (rd_i),
  .low_power_i   (low_power_i),
  .rvalid_o      (rvalid_o),
  .busy_o        (busy_o),
  .ctrl_o        (ctrl_o),
  .pump_clk_en_o (pump_clk_en_o),
  .pump_on_o     (pump_on_o),
  .hv_array_o    (hv_array_o)
);

// *** faec_top_tb.sv ***
`timescale 1ns/1ps
module faec_top_tb;
  logic        clk_i;
  logic        rstn_i;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  array_sense_i;
  logic        low_power_i;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        busy_o;
  logic [7:0]  ctrl_o;
  logic        pump_clk_en_o;
  logic        pump_on_o;
  logic        hv_array_o;
  logic [8:0]  erase_block_o;
  logic [8:0]  erase_mask_o;
  logic [11:0] program_page_o;
  logic        prog_latch_o;
  logic        protect_bypass_i;
  int          bad_count;
  int          compares;
  int          n;
  logic [7:0]  d;
  localparam logic [15:0] CA = faec_pkg::CTRL_ADDR;
  localparam logic [8:0]  MASK [4] = '{9'h000, 9'h100, 9'h1f8, 9'h1ff};
  localparam int          DIV [4] = '{1, 2, 2, 4};

  faec_top faec_top_i
  (
    .clk_i            (clk_i),
    .rstn_i           (rstn_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_i             (wr_i),
    .rd_i             (rd_i),
    .array_sense_i    (array_sense_i),
    .protect_bypass_i (protect_bypass_i),
    .low_power_i      (low_power_i),
    .rdata_o          (rdata_o),
    .rvalid_o         (rvalid_o),
    .busy_o           (busy_o),
    .ctrl_o           (ctrl_o),
    .pump_clk_en_o    (pump_clk_en_o),
    .pump_on_o        (pump_on_o),
    .hv_array_o       (hv_array_o),
    .erase_block_o    (erase_block_o),
    .erase_mask_o     (erase_mask_o),
    .program_page_o   (program_page_o),
    .prog_latch_o     (prog_latch_o)
  );

  // ****
  // Bus and check tasks
  // ****
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask

  // Leaves in n the cycles from strobe release to the answer
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    n = 0;
    while (rvalid_o !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      end_sim();
    end
    v = rdata_o;
  endtask

  // Mode select, protect byte read, then the block-choosing write
  task automatic setup(input logic [7:0] c, input logic [7:0] prot, input logic [15:0] a);
    wr(CA, c);
    array_sense_i = ~prot;
    rd(faec_pkg::PROTECT_ADDR, d);
    wr(a, 8'h5a);
  endtask

  // ****
  // Stimulus
  // ****
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end

  initial
  begin
    rstn_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    array_sense_i = 8'h0f;
    low_power_i = 1'b0;
    protect_bypass_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    chk(ctrl_o, 8'h00);
    rd(CA, d);
    chk(d, 8'h00);
    rd(16'h0e00, d);
    chk(d, 8'hf0);
    chk(n, 0);
    rd(16'h0580, d);
    chk(d, 8'hf0);
    rd(16'h9000, d);
    chk(d, 8'h00);
    wr(CA, 8'h03);
    rd(CA, d);
    chk(d, 8'h00);
    wr(CA, 8'h08);
    rd(CA, d);
    chk(d, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      setup({2'b00, b[1:0], 4'h2}, 8'h00, 16'h5e40);
      @(negedge clk_i);
      chk(erase_mask_o, MASK[b]);
      chk(erase_block_o, 9'h179 & MASK[b]);
      wr(CA, 8'h00);
    end
    for (int f = 0; f < 4; f++)
    begin
      setup({f[1:0], 6'h32}, 8'h00, 16'h0e00);
      wr(CA, {f[1:0], 6'h3a});
      repeat (3) @(negedge clk_i);
      chk(hv_array_o, 1'b1);
      chk(pump_on_o, 1'b1);
      n = 0;
      repeat (16)
      begin
        @(negedge clk_i);
        n += int'(pump_clk_en_o);
      end
      chk(n, 16 / DIV[f]);
      low_power_i = 1'b1;
      wr(CA, {f[1:0], 6'h3e});
      chk(pump_on_o, 1'b0);
      chk(hv_array_o, 1'b0);
      rd(CA, d);
      chk(d, {f[1:0], 6'h3a});
      low_power_i = 1'b0;
      wr(CA, {f[1:0], 6'h32});
      wr(CA, 8'h00);
    end
    // One pass per page: program, unrelated read, then high voltage
    setup(8'h01, 8'h00, 16'h1238);
    chk(prog_latch_o, 1'b1);
    chk(program_page_o, 12'h247);
    @(negedge clk_i);
    chk(prog_latch_o, 1'b0);
    rd(16'h9000, d);
    chk(d, 8'h00);
    wr(CA, 8'h09);
    @(negedge clk_i);
    chk(hv_array_o, 1'b1);
    wr(CA, 8'h01);
    wr(CA, 8'h00);
    setup(8'h02, 8'h01, 16'h0e00);
    rd(CA, d);
    chk(d, 8'h00);
    protect_bypass_i = 1'b1;
    setup(8'h02, 8'h01, 16'h0e00);
    rd(CA, d);
    chk(d, 8'h02);
    protect_bypass_i = 1'b0;
    wr(CA, 8'h00);
    wr(CA, 8'h0a);
    rd(CA, d);
    chk(d, 8'h02);
    wr(CA, 8'h04);
    array_sense_i = 8'h3c;
    rd(16'h0e00, d);
    chk(n, 8);
    chk(d, 8'hc3);
    wr(CA, 8'h00);
    end_sim();
  end
endmodule
